// ==== shared/efc_regs.vh ====
// Constants for the embedded flash controller
`ifndef EFC_REGS_VH
`define EFC_REGS_VH
// Clock and timing (times in their printed units)
`define EFC_CLK_MHZ 125
`define EFC_T_WR_NS 46000
`define EFC_T_PAGE_NS 3040000
`define EFC_PAGE_WORDS 128
`define EFC_T_ERASE_US 21000
`define EFC_T_DIS_NS 6600
`define EFC_T_MDIS_NS 121000
`define EFC_WR_CYC ((`EFC_T_WR_NS * `EFC_CLK_MHZ + 999) / 1000)
`define EFC_SEQ_CYC (((`EFC_T_PAGE_NS - `EFC_T_WR_NS) * `EFC_CLK_MHZ + 126999) / 127000)
`define EFC_ERASE_CYC (`EFC_T_ERASE_US * `EFC_CLK_MHZ)
`define EFC_DIS_CYC ((`EFC_T_DIS_NS * `EFC_CLK_MHZ + 999) / 1000)
`define EFC_MDIS_CYC ((`EFC_T_MDIS_NS * `EFC_CLK_MHZ + 999) / 1000)
`define EFC_TW 22
// Address map
`define EFC_MMR_PAGE 24'h400180
`define EFC_USER_END 32'h00020000
`define EFC_INFO_END 32'h00020800
`define EFC_RD_LO 32'h000207E8
`define EFC_RD_HI 32'h000207F4
`define EFC_A_REV 32'h000207E8
`define EFC_A_UNUSED 32'h000207EC
`define EFC_A_ID_LO 32'h000207F0
`define EFC_UNUSED_VAL 32'h000000FF
`define EFC_WP_LOC 18'h1FFF8
`define EFC_DBG_LOC 18'h1FFEC
`define EFC_KEYLOC_LO 18'h1FFEC
`define EFC_DBG_SIG 32'h16032010
`define EFC_SZ_WORD 2'h2
`define EFC_PAGE_LSB 9
`define EFC_BLK_LSB 12
`define EFC_PAGE_LAST 9'h1FC
// Register offsets (address bits 7:0)
`define EFC_OFS_STA 8'h00
`define EFC_OFS_CON0 8'h04
`define EFC_OFS_CMD 8'h08
`define EFC_OFS_KEY 8'h0C
`define EFC_OFS_DBG 8'h10
`define EFC_OFS_SALO 8'h14
`define EFC_OFS_SAHI 8'h18
`define EFC_OFS_EALO 8'h1C
`define EFC_OFS_EAHI 8'h20
`define EFC_OFS_SIGN 8'h24
`define EFC_OFS_WP 8'h28
// Fields
`define EFC_CON0_WREN 2
`define EFC_CON0_ABEN 3
`define EFC_KEY1 16'hF456
`define EFC_KEY2 16'hF123
`define EFC_KEY_NONE 2'h0
`define EFC_KEY_HALF 2'h1
`define EFC_KEY_FULL 2'h2
`define EFC_CMD_PAGE 4'h1
`define EFC_CMD_SIGN 4'h2
`define EFC_CMD_MASS 4'h3
`define EFC_CMD_ABORT 4'h4
`define EFC_RES_OK 2'h0
`define EFC_RES_DENY 2'h1
`define EFC_RES_FAIL 2'h2
`define EFC_RES_ABORT 2'h3
`define EFC_CRC_POLY 24'h800063
`define EFC_CRC_INIT 24'hFFFFFF
`endif

// ==== rtl/efc_timer.v ====
// Down counter timing flash operations
`timescale 1ns/100ps
module efc_timer #(
    parameter W = 22
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Control
    input wire load,
    input wire [W-1:0] value,
    // Expiry pulse
    output reg done_q
);
    reg [W-1:0] cnt_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= {W{1'b0}};
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (load) begin
                cnt_q <= value;
            end else if (cnt_q != {W{1'b0}}) begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule // efc_timer

// ==== rtl/efc_top.v ====
// Embedded flash controller: bus access, protection, erase/write/sign
`timescale 1ns/100ps
`include "efc_regs.vh"
module efc_top #(
    parameter [`EFC_TW-1:0] WR_CYC = `EFC_WR_CYC,
    parameter [`EFC_TW-1:0] ERASE_CYC = `EFC_ERASE_CYC,
    parameter [`EFC_TW-1:0] MDIS_CYC = `EFC_MDIS_CYC,
    parameter [31:0] KERNEL_REV = 32'h30303031, // arbitrary value
    parameter [63:0] SILICON_ID = 64'h0123456789ABCDEF // arbitrary value
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Processor memory bus
    input wire bus_req,
    input wire bus_we,
    input wire [1:0] bus_size,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_wdata,
    output reg bus_ready_q,
    output reg bus_err_q,
    output reg [31:0] bus_rdata_q,
    // System interrupt pin for abort
    input wire irq_any,
    // Flash core
    input wire [31:0] fc_rdata,
    output reg [17:0] fc_addr_q,
    output reg [31:0] fc_wdata_q,
    output reg fc_rd_q,
    output reg fc_prog_q,
    output reg fc_erase_page_q,
    output reg fc_erase_mass_q,
    output reg fc_stop_q,
    // Debug port enable
    output reg swd_enable_q
);
    localparam [6:0] S_LOAD = 7'h01;
    localparam [6:0] S_IDLE = 7'h02;
    localparam [6:0] S_READ = 7'h04;
    localparam [6:0] S_WRITE = 7'h08;
    localparam [6:0] S_ERASE = 7'h10;
    localparam [6:0] S_SIGN = 7'h20;
    localparam [6:0] S_DISCH = 7'h40;
    localparam [`EFC_TW-1:0] SEQ_CYC = `EFC_SEQ_CYC;
    localparam [`EFC_TW-1:0] DIS_CYC = `EFC_DIS_CYC;

    reg [6:0] st_q;
    reg irq_m_q;
    reg irq_s_q;
    reg [1:0] key_q;
    reg wren_q;
    reg aben_q;
    reg [31:0] wp_q;
    reg [15:0] sa_lo_q;
    reg [15:0] sa_hi_q;
    reg [15:0] ea_lo_q;
    reg [15:0] ea_hi_q;
    reg [23:0] sig_q;
    reg cdone_q;
    reg wdone_q;
    reg [1:0] res_q;
    reg [17:0] last_wr_q;
    reg last_ok_q;
    reg [17:0] sign_end_q;
    reg from_wr_q;
    reg tm_load_q;
    reg [`EFC_TW-1:0] tm_val_q;
    wire tm_done;

    efc_timer #(.W(`EFC_TW)) u_timer (
        .clk(clk),
        .nrst(nrst),
        .load(tm_load_q),
        .value(tm_val_q),
        .done_q(tm_done)
    );

    function [23:0] crc_step;
        input [23:0] c;
        input [31:0] d;
        integer i;
        reg fb;
        begin
            crc_step = c;
            for (i = 31; i >= 0; i = i - 1) begin
                fb = crc_step[23] ^ d[i];
                crc_step = {crc_step[22:0], 1'b0} ^ (fb ? `EFC_CRC_POLY : 24'h000000);
            end
        end
    endfunction

    // Request decode
    wire take = bus_req & ~bus_ready_q;
    wire is_mmr = (bus_addr[31:8] == `EFC_MMR_PAGE);
    wire is_user = (bus_addr < `EFC_USER_END);
    wire is_info = ~is_user & (bus_addr < `EFC_INFO_END);
    wire info_ok = (bus_addr >= `EFC_RD_LO) & (bus_addr <= `EFC_RD_HI)
        & (bus_addr[1:0] == 2'h0);
    wire [17:0] fa = bus_addr[17:0];
    wire key_ok = (key_q == `EFC_KEY_FULL);
    wire wp_hit = ~wp_q[fa[16:`EFC_BLK_LSB]];
    wire cmd_busy = st_q[4] | st_q[5] | st_q[6] | st_q[0];
    wire wr_err = ~is_user | (bus_size != `EFC_SZ_WORD) | (bus_addr[1:0] != 2'h0)
        | ~wren_q | wp_hit | ((fa >= `EFC_KEYLOC_LO) & ~key_ok);
    wire rd_err = ~is_user & ~(is_info & info_ok);
    wire seq_wr = last_ok_q & (fa == last_wr_q + 18'h4)
        & (fa[17:`EFC_PAGE_LSB] == last_wr_q[17:`EFC_PAGE_LSB]);
    wire [8:0] wp_bit = {4'h0, sa_hi_q[0], sa_lo_q[15:12]};
    wire [17:0] sa_page = {sa_hi_q[1:0], sa_lo_q[15:`EFC_PAGE_LSB], 9'h000};
    wire [17:0] ea_last = {ea_hi_q[1:0], ea_lo_q[15:`EFC_PAGE_LSB], `EFC_PAGE_LAST};
    reg [31:0] mmr_rd;
    reg [31:0] info_rd;

    always @* begin
        case (bus_addr[7:0])
            `EFC_OFS_STA: mmr_rd = {26'h0, res_q, wdone_q, cdone_q, st_q[3], cmd_busy};
            `EFC_OFS_CON0: mmr_rd = {28'h0, aben_q, wren_q, 2'h0};
            `EFC_OFS_DBG: mmr_rd = {31'h0, swd_enable_q};
            `EFC_OFS_SALO: mmr_rd = {16'h0, sa_lo_q};
            `EFC_OFS_SAHI: mmr_rd = {16'h0, sa_hi_q};
            `EFC_OFS_EALO: mmr_rd = {16'h0, ea_lo_q};
            `EFC_OFS_EAHI: mmr_rd = {16'h0, ea_hi_q};
            `EFC_OFS_SIGN: mmr_rd = {8'h00, sig_q};
            `EFC_OFS_WP: mmr_rd = wp_q;
            default: mmr_rd = 32'h00000000;
        endcase
    end

    always @* begin
        if (bus_addr == `EFC_A_REV)
            info_rd = KERNEL_REV;
        else if (bus_addr == `EFC_A_UNUSED)
            info_rd = `EFC_UNUSED_VAL;
        else if (bus_addr == `EFC_A_ID_LO)
            info_rd = SILICON_ID[31:0];
        else
            info_rd = SILICON_ID[63:32];
    end

    // Pin synchroniser
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_m_q <= 1'b0;
            irq_s_q <= 1'b0;
        end else begin
            irq_m_q <= irq_any;
            irq_s_q <= irq_m_q;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= S_LOAD;
            bus_ready_q <= 1'b0;
            bus_err_q <= 1'b0;
            bus_rdata_q <= 32'h00000000;
            fc_addr_q <= 18'h00000;
            fc_wdata_q <= 32'h00000000;
            fc_rd_q <= 1'b0;
            fc_prog_q <= 1'b0;
            fc_erase_page_q <= 1'b0;
            fc_erase_mass_q <= 1'b0;
            fc_stop_q <= 1'b0;
            swd_enable_q <= 1'b0;
            key_q <= `EFC_KEY_NONE;
            wren_q <= 1'b0;
            aben_q <= 1'b0;
            wp_q <= 32'hFFFFFFFF;
            sa_lo_q <= 16'h0000;
            sa_hi_q <= 16'h0000;
            ea_lo_q <= 16'h0000;
            ea_hi_q <= 16'h0000;
            sig_q <= `EFC_CRC_INIT;
            cdone_q <= 1'b0;
            wdone_q <= 1'b0;
            res_q <= `EFC_RES_OK;
            last_wr_q <= 18'h00000;
            last_ok_q <= 1'b0;
            sign_end_q <= 18'h00000;
            from_wr_q <= 1'b0;
            tm_load_q <= 1'b0;
            tm_val_q <= {`EFC_TW{1'b0}};
        end else begin
            bus_ready_q <= 1'b0;
            bus_err_q <= 1'b0;
            fc_prog_q <= 1'b0;
            fc_erase_page_q <= 1'b0;
            fc_erase_mass_q <= 1'b0;
            fc_stop_q <= 1'b0;
            tm_load_q <= 1'b0;
            // Register accesses are served unless a direct access owns the bus
            if (take & is_mmr & ~st_q[2] & ~st_q[3]) begin
                bus_ready_q <= 1'b1;
                bus_rdata_q <= bus_we ? 32'h00000000 : mmr_rd;
                last_ok_q <= 1'b0;
                if (!bus_we && bus_addr[7:0] == `EFC_OFS_STA) begin
                    cdone_q <= 1'b0;
                    wdone_q <= 1'b0;
                end
                if (bus_we) begin
                    case (bus_addr[7:0])
                        `EFC_OFS_CON0: begin
                            wren_q <= bus_wdata[`EFC_CON0_WREN];
                            aben_q <= bus_wdata[`EFC_CON0_ABEN];
                        end
                        `EFC_OFS_KEY: begin
                            if (key_q == `EFC_KEY_NONE && bus_wdata[15:0] == `EFC_KEY1)
                                key_q <= `EFC_KEY_HALF;
                            else if (key_q == `EFC_KEY_HALF && bus_wdata[15:0] == `EFC_KEY2)
                                key_q <= `EFC_KEY_FULL;
                            else
                                key_q <= `EFC_KEY_NONE;
                        end
                        `EFC_OFS_DBG: begin
                            if (!bus_wdata[0])
                                swd_enable_q <= 1'b0;
                        end
                        `EFC_OFS_SALO: sa_lo_q <= bus_wdata[15:0];
                        `EFC_OFS_SAHI: sa_hi_q <= bus_wdata[15:0];
                        `EFC_OFS_EALO: ea_lo_q <= bus_wdata[15:0];
                        `EFC_OFS_EAHI: ea_hi_q <= bus_wdata[15:0];
                        `EFC_OFS_WP: begin
                            if (key_ok)
                                wp_q <= bus_wdata;
                        end
                        `EFC_OFS_CMD: begin
                            if (bus_wdata[3:0] == `EFC_CMD_ABORT && (st_q[4] | st_q[5])) begin
                                fc_stop_q <= 1'b1;
                                fc_rd_q <= 1'b0;
                                res_q <= `EFC_RES_ABORT;
                                tm_load_q <= 1'b1;
                                tm_val_q <= fc_erase_mass_q ? MDIS_CYC : DIS_CYC;
                                from_wr_q <= 1'b0;
                                st_q <= S_DISCH;
                            end else if (st_q[1]) begin
                                res_q <= `EFC_RES_OK;
                                if (bus_wdata[3:0] == `EFC_CMD_SIGN) begin
                                    fc_addr_q <= sa_page;
                                    sign_end_q <= ea_last;
                                    sig_q <= `EFC_CRC_INIT;
                                    fc_rd_q <= 1'b1;
                                    st_q <= S_SIGN;
                                end else if (bus_wdata[3:0] == `EFC_CMD_PAGE ||
                                             bus_wdata[3:0] == `EFC_CMD_MASS) begin
                                    if (!key_ok || (bus_wdata[3:0] == `EFC_CMD_PAGE &&
                                        !wp_q[wp_bit[4:0]]) || (bus_wdata[3:0] ==
                                        `EFC_CMD_MASS && !wp_q[31])) begin
                                        res_q <= `EFC_RES_DENY;
                                        cdone_q <= 1'b1;
                                        key_q <= `EFC_KEY_NONE;
                                    end else begin
                                        fc_addr_q <= sa_page;
                                        fc_erase_page_q <= (bus_wdata[3:0] == `EFC_CMD_PAGE);
                                        fc_erase_mass_q <= (bus_wdata[3:0] == `EFC_CMD_MASS);
                                        tm_load_q <= 1'b1;
                                        tm_val_q <= ERASE_CYC;
                                        st_q <= S_ERASE;
                                    end
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end
            case (st_q)
                S_LOAD: begin
                    if (!fc_rd_q) begin
                        fc_rd_q <= 1'b1;
                        fc_addr_q <= `EFC_WP_LOC;
                    end else if (fc_addr_q == `EFC_WP_LOC) begin
                        wp_q <= fc_rdata;
                        fc_addr_q <= `EFC_DBG_LOC;
                    end else begin
                        swd_enable_q <= (fc_rdata != `EFC_DBG_SIG);
                        fc_rd_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (take & ~is_mmr) begin
                        last_ok_q <= 1'b0;
                        if (bus_we ? wr_err : rd_err) begin
                            bus_ready_q <= 1'b1;
                            bus_err_q <= 1'b1;
                            bus_rdata_q <= 32'h00000000;
                        end else if (!bus_we && is_info) begin
                            bus_ready_q <= 1'b1;
                            bus_rdata_q <= info_rd;
                        end else if (!bus_we) begin
                            fc_rd_q <= 1'b1;
                            fc_addr_q <= fa;
                            st_q <= S_READ;
                        end else begin
                            fc_prog_q <= 1'b1;
                            fc_addr_q <= fa;
                            fc_wdata_q <= bus_wdata;
                            tm_load_q <= 1'b1;
                            tm_val_q <= seq_wr ? SEQ_CYC : WR_CYC;
                            st_q <= S_WRITE;
                        end
                    end
                end
                S_READ: begin
                    fc_rd_q <= 1'b0;
                    bus_ready_q <= 1'b1;
                    bus_rdata_q <= fc_rdata;
                    st_q <= S_IDLE;
                end
                S_WRITE: begin
                    if (aben_q & irq_s_q) begin
                        fc_stop_q <= 1'b1;
                        res_q <= `EFC_RES_ABORT;
                        tm_load_q <= 1'b1;
                        tm_val_q <= DIS_CYC;
                        from_wr_q <= 1'b1;
                        st_q <= S_DISCH;
                    end else if (tm_done) begin
                        bus_ready_q <= 1'b1;
                        wdone_q <= 1'b1;
                        last_wr_q <= fc_addr_q;
                        last_ok_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_ERASE: begin
                    if (aben_q & irq_s_q) begin
                        fc_stop_q <= 1'b1;
                        res_q <= `EFC_RES_ABORT;
                        tm_load_q <= 1'b1;
                        tm_val_q <= fc_erase_mass_q ? MDIS_CYC : DIS_CYC;
                        from_wr_q <= 1'b0;
                        st_q <= S_DISCH;
                    end else if (tm_done) begin
                        cdone_q <= 1'b1;
                        key_q <= `EFC_KEY_NONE;
                        st_q <= S_IDLE;
                    end
                end
                S_SIGN: begin
                    if (aben_q & irq_s_q) begin
                        fc_rd_q <= 1'b0;
                        res_q <= `EFC_RES_ABORT;
                        cdone_q <= 1'b1;
                        key_q <= `EFC_KEY_NONE;
                        st_q <= S_IDLE;
                    end else if (fc_rd_q) begin
                        // Two cycles a word, paced by this clock only
                        fc_rd_q <= 1'b0;
                        if (fc_addr_q >= sign_end_q) begin
                            if (fc_rdata[23:0] != sig_q)
                                res_q <= `EFC_RES_FAIL;
                            cdone_q <= 1'b1;
                            key_q <= `EFC_KEY_NONE;
                            st_q <= S_IDLE;
                        end else begin
                            sig_q <= crc_step(sig_q, fc_rdata);
                            fc_addr_q <= fc_addr_q + 18'h4;
                        end
                    end else begin
                        fc_rd_q <= 1'b1;
                    end
                end
                S_DISCH: begin
                    if (tm_done) begin
                        if (from_wr_q) begin
                            bus_ready_q <= 1'b1;
                            wdone_q <= 1'b1;
                        end else begin
                            cdone_q <= 1'b1;
                            key_q <= `EFC_KEY_NONE;
                        end
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // efc_top

// ==== bench/efc_props.sv ====
// Port checker for the embedded flash controller
`timescale 1ns/100ps
module efc_props #(
    parameter [21:0] WR_CYC = 22'h14
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Processor bus
    input wire bus_req,
    input wire bus_we,
    input wire [1:0] bus_size,
    input wire [31:0] bus_addr,
    input wire bus_ready_q,
    input wire bus_err_q,
    input wire [31:0] bus_rdata_q,
    // Flash core strobes
    input wire fc_rd_q,
    input wire fc_prog_q,
    input wire fc_erase_page_q,
    input wire fc_erase_mass_q
);
    reg [21:0] wcnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles since the last program pulse
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            wcnt_q <= 22'h0;
        else if (bus_ready_q)
            wcnt_q <= 22'h0;
        else if (fc_prog_q)
            wcnt_q <= 22'h1;
        else if (wcnt_q != 22'h0)
            wcnt_q <= wcnt_q + 22'h1;
    end
    sequence s_erase_start;
        fc_erase_page_q || fc_erase_mass_q;
    endsequence
    sequence s_core_quiet;
        (!fc_rd_q && !fc_prog_q) [*8];
    endsequence
    a_err_has_ready: assert property (bus_err_q |-> bus_ready_q)
        else $error("bus fault without ready");
    a_ready_single: assert property (bus_ready_q |=> !bus_ready_q)
        else $error("ready longer than one cycle");
    a_ready_needs_req: assert property (bus_ready_q |-> $past(bus_req))
        else $error("answer without request");
    a_size_fault: assert property (bus_ready_q && $past(bus_we) && $past(bus_size) != 2'h2
        && $past(bus_addr) < 32'h20000 |-> bus_err_q) else $error("narrow access not faulted");
    a_prog_pulse: assert property (fc_prog_q |=> !fc_prog_q)
        else $error("program strobe too long");
    a_write_time: assert property (bus_ready_q && wcnt_q != 22'h0 |-> wcnt_q >= WR_CYC)
        else $error("write answered early");
    a_erase_stall: assert property (s_erase_start |=> s_core_quiet)
        else $error("core access during erase");
    a_hole_fault: assert property (bus_ready_q && !$past(bus_we) && $past(bus_addr) >= 32'h20000
        && $past(bus_addr) < 32'h207E8 |-> bus_err_q) else $error("hole read not faulted");
    a_unused_word: assert property (bus_ready_q && !$past(bus_we)
        && $past(bus_addr) == 32'h207EC && $past(bus_size) == 2'h2
        |-> !bus_err_q && bus_rdata_q == 32'hFF) else $error("unused word wrong");
endmodule // efc_props

// ==== bench/efc_flash_model.sv ====
// Behavioural flash array behind the controller's core strobes
`timescale 1ns/100ps
module efc_flash_model (
    // Clock
    input wire clk,
    // Core strobes
    input wire [17:0] fc_addr_q,
    input wire [31:0] fc_wdata_q,
    input wire fc_rd_q,
    input wire fc_prog_q,
    input wire fc_erase_page_q,
    input wire fc_erase_mass_q,
    // Read data
    output wire [31:0] fc_rdata
);
    logic [31:0] mem [0:32767];
    logic [31:0] last_q = 32'h0;
    integer i;
    initial begin
        for (i = 0; i < 32768; i = i + 1)
            mem[i] = 32'hFFFFFFFF;
        mem[15'h7FFE] = 32'hFFFFFFFD; // Block 1 protected
    end
    always @(posedge clk) begin
        if (fc_rd_q)
            last_q <= fc_rdata;
        if (fc_prog_q)
            mem[fc_addr_q[16:2]] <= mem[fc_addr_q[16:2]] & fc_wdata_q;
        if (fc_erase_page_q)
            for (i = 0; i < 128; i = i + 1)
                mem[{fc_addr_q[16:9], 7'h0} + i] <= 32'hFFFFFFFF;
        if (fc_erase_mass_q)
            for (i = 0; i < 32768; i = i + 1)
                mem[i] <= 32'hFFFFFFFF;
    end
    // Data is only valid under the read strobe
    assign fc_rdata = fc_rd_q ? mem[fc_addr_q[16:2]] : ~last_q;
endmodule // efc_flash_model

// ==== bench/efc_top_bench.sv ====
// Self-checking bench for the embedded flash controller
`timescale 1ns/100ps
`include "efc_regs.vh"
module efc_top_bench;
    localparam [31:0] RB = 32'h40018000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic bus_req = 1'b0;
    logic bus_we = 1'b0;
    logic [1:0] bus_size = 2'h2;
    logic [31:0] bus_addr = 32'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic irq_any = 1'b0;
    wire bus_ready_q, bus_err_q, fc_rd_q, fc_prog_q, fc_erase_page_q, fc_erase_mass_q;
    wire fc_stop_q, swd_enable_q;
    wire [31:0] bus_rdata_q, fc_rdata, fc_wdata_q;
    wire [17:0] fc_addr_q;
    logic [31:0] rd;
    logic er;
    int cyc, base, bad_count = 0, n_tests = 0;
    efc_top #(.WR_CYC(22'h14), .ERASE_CYC(22'h32), .MDIS_CYC(22'h1E)) DUT (.clk(clk),
        .nrst(nrst), .bus_req(bus_req), .bus_we(bus_we), .bus_size(bus_size),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ready_q(bus_ready_q),
        .bus_err_q(bus_err_q), .bus_rdata_q(bus_rdata_q), .irq_any(irq_any),
        .fc_rdata(fc_rdata), .fc_addr_q(fc_addr_q), .fc_wdata_q(fc_wdata_q), .fc_rd_q(fc_rd_q),
        .fc_prog_q(fc_prog_q), .fc_erase_page_q(fc_erase_page_q),
        .fc_erase_mass_q(fc_erase_mass_q), .fc_stop_q(fc_stop_q), .swd_enable_q(swd_enable_q));
    efc_flash_model u_flash (.clk(clk), .fc_addr_q(fc_addr_q), .fc_wdata_q(fc_wdata_q),
        .fc_rd_q(fc_rd_q), .fc_prog_q(fc_prog_q), .fc_erase_page_q(fc_erase_page_q),
        .fc_erase_mass_q(fc_erase_mass_q), .fc_rdata(fc_rdata));
    always #4 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle, held until ready is sampled high
    task automatic bus(input logic we, input logic [1:0] sz, input logic [31:0] a,
        input logic [31:0] d);
        cyc = 0;
        @(posedge clk);
        bus_req <= 1'b1;
        bus_we <= we;
        bus_size <= sz;
        bus_addr <= a;
        bus_wdata <= d;
        do begin
            @(posedge clk);
            cyc = cyc + 1;
        end while (bus_ready_q !== 1'b1 && cyc < 5000);
        if (bus_ready_q !== 1'b1) bad_count = bad_count + 1;
        rd = bus_rdata_q;
        er = bus_err_q;
        bus_req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        bus(1'b1, 2'h2, RB + o, d);
    endtask
    task automatic rdr(input logic [7:0] o);
        bus(1'b0, 2'h2, RB + o, 32'h0);
    endtask
    task automatic t_reset;
        check(swd_enable_q, 32'h1);
        rdr(`EFC_OFS_WP);
        check(rd, 32'hFFFFFFFD);
        rdr(8'h40);
        check(rd, 32'h0);
        check(er, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_write;
        wr(`EFC_OFS_CON0, 32'h4);
        bus(1'b0, 2'h2, 32'h2000, 32'h0);
        base = cyc;
        bus(1'b1, 2'h2, 32'h2000, 32'h12345678);
        check(32'(cyc - base), 32'h15);
        check(er, 32'h0);
        bus(1'b1, 2'h2, 32'h2004, 32'hA5A55A5A);
        check(32'(cyc - base), 32'h0B84);
        rdr(`EFC_OFS_STA);
        check(rd & 32'hB, 32'h8);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h8, 32'h0);
        bus(1'b0, 2'h2, 32'h2004, 32'h0);
        check(rd, 32'hA5A55A5A);
        $display("write test done");
    endtask
    task automatic t_faults;
        bus(1'b1, 2'h0, 32'h2008, 32'h0);
        check(er, 32'h1);
        bus(1'b1, 2'h2, 32'h1000, 32'h0);
        check(er, 32'h1);
        bus(1'b1, 2'h2, 32'h1FFEC, 32'h0);
        check(er, 32'h1);
        bus(1'b0, 2'h2, 32'h20000, 32'h0);
        check(er, 32'h1);
        bus(1'b0, 2'h2, 32'h207EC, 32'h0);
        check(er, 32'h0);
        check(rd, 32'hFF);
        wr(`EFC_OFS_CON0, 32'h0);
        bus(1'b1, 2'h2, 32'h2010, 32'h0);
        check(er, 32'h1);
        $display("fault test done");
    endtask
    task automatic t_erase;
        wr(`EFC_OFS_CMD, 32'h1);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h34, 32'h14);
        bus(1'b0, 2'h2, 32'h2000, 32'h0);
        check(rd, 32'h12345678);
        wr(`EFC_OFS_KEY, 32'hF456);
        wr(`EFC_OFS_KEY, 32'hF123);
        wr(`EFC_OFS_SALO, 32'h2000);
        wr(`EFC_OFS_SAHI, 32'h0);
        wr(`EFC_OFS_CMD, 32'h1);
        bus(1'b0, 2'h2, 32'h2004, 32'h0);
        check(cyc > 49, 32'h1);
        check(rd, 32'hFFFFFFFF);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h34, 32'h4);
        wr(`EFC_OFS_CMD, 32'h1);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h34, 32'h14);
        wr(`EFC_OFS_KEY, 32'hF456);
        wr(`EFC_OFS_KEY, 32'h1234);
        wr(`EFC_OFS_KEY, 32'hF123);
        wr(`EFC_OFS_CMD, 32'h3);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h34, 32'h14);
        wr(`EFC_OFS_KEY, 32'hF456);
        wr(`EFC_OFS_KEY, 32'hF123);
        wr(`EFC_OFS_CMD, 32'h3);
        bus(1'b0, 2'h2, 32'h1FFF8, 32'h0);
        check(rd, 32'hFFFFFFFF);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h34, 32'h4);
        $display("erase test done");
    endtask
    task automatic t_sign;
        logic [23:0] c = `EFC_CRC_INIT;
        repeat (32'hFE0) c = {c[22:0], 1'b0} ^ (c[23] ? 24'h0 : `EFC_CRC_POLY);
        wr(`EFC_OFS_EALO, 32'h2000);
        wr(`EFC_OFS_CMD, 32'h2);
        bus(1'b0, 2'h2, 32'h2000, 32'h0);
        rdr(`EFC_OFS_STA);
        check(rd & 32'h34, c == 24'hFFFFFF ? 32'h4 : 32'h24);
        rdr(`EFC_OFS_SIGN);
        check(rd, {8'h00, c});
        wr(`EFC_OFS_CON0, 32'hC);
        irq_any <= 1'b1;
        bus(1'b1, 2'h2, 32'h2008, 32'h0);
        irq_any <= 1'b0;
        rdr(`EFC_OFS_STA);
        check(rd & 32'h3B, 32'h38);
        $display("sign test done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset;
        t_write;
        t_faults;
        t_erase;
        t_sign;
        wrap_up;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #320000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule // efc_top_bench
bind efc_top efc_props #(.WR_CYC(WR_CYC)) u_props (.clk(clk), .nrst(nrst), .bus_req(bus_req),
    .bus_we(bus_we), .bus_size(bus_size), .bus_addr(bus_addr), .bus_ready_q(bus_ready_q),
    .bus_err_q(bus_err_q), .bus_rdata_q(bus_rdata_q), .fc_rd_q(fc_rd_q), .fc_prog_q(fc_prog_q),
    .fc_erase_page_q(fc_erase_page_q), .fc_erase_mass_q(fc_erase_mass_q));
